/* include/omx_pkg.sv */
// Constants for the output mux select register bank
package omx_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register port widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] RESERVED_CFG_A_OFS          = 8'h16;
  localparam logic [7:0] RESERVED_CFG_B_OFS          = 8'h17;
  localparam logic [7:0] RESERVED_CFG_C_OFS          = 8'h18;
  localparam logic [7:0] RESERVED_CFG_D_OFS          = 8'h19;
  localparam logic [7:0] RESERVED_CFG_E_OFS          = 8'h1A;
  localparam logic [7:0] RESERVED_CFG_F_OFS          = 8'h1B;
  localparam logic [7:0] PRIMARY_OUTPUT_SELECT_OFS   = 8'h1C;
  localparam logic [7:0] RESERVED_CFG_G_OFS          = 8'h1D;
  localparam logic [7:0] SECONDARY_OUTPUT_SELECT_OFS = 8'h1E;

  // Bank spans one contiguous block of offsets
  localparam logic [7:0] BANK_FIRST_OFS = RESERVED_CFG_A_OFS;
  localparam int         BANK_REGS      = 9;
  localparam int         IDX_W          = 4;
  localparam logic [3:0] PRI_IDX        = 4'h6;
  localparam logic [3:0] SEC_IDX        = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values, indexed from the first offset
  localparam logic [7:0] BANK_RESET [BANK_REGS] = '{
    8'h25, 8'h25, 8'h40, 8'h00, 8'hA0, 8'h03, 8'h58, 8'h00, 8'h09
  };

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int PRI_CODE_LSB   = 5;
  localparam int DIV_PICK_BIT   = 4;
  localparam int COMB_CTRL_LSB  = 2;
  localparam int SEC_CODE_LSB   = 5;
  localparam int CODE_W         = 3;
  localparam int COMB_W         = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Primary output codes
  localparam logic [2:0] PRI_MUTE    = 3'h0;
  localparam logic [2:0] PRI_CLK10M  = 3'h1;
  localparam logic [2:0] PRI_RAW     = 3'h2;
  localparam logic [2:0] PRI_RETIMED = 3'h4;

  // Secondary output codes
  localparam logic [2:0] SEC_RAW     = 3'h0;
  localparam logic [2:0] SEC_RETIMED = 3'h1;
  localparam logic [2:0] SEC_OSC     = 3'h2;
  localparam logic [2:0] SEC_DIVCLK  = 3'h5;
  localparam logic [2:0] SEC_MUTE    = 3'h7;

  // Divide pick: 0 is the 10 MHz clock, 1 the oscillator over 40
  localparam logic DIV_PICK_10M   = 1'h0;
  localparam logic DIV_PICK_DIV40 = 1'h1;

  // Combined output control codes
  localparam logic [1:0] COMB_MUTE_BOTH = 2'h0;
  localparam logic [1:0] COMB_CLK_OUT   = 2'h1;
  localparam logic [1:0] COMB_RETIMED   = 2'h2;
  localparam logic [1:0] COMB_RAW       = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser
  localparam int SYNC_STAGES = 3;
  localparam int SYNC_BITS   = 4;
  localparam logic [3:0] SYNC_RESET = 4'h2;

endpackage : omx_pkg

/* include/omx_sel_if.sv */
// Carrier between the register bank and the automatic source selector
`timescale 1ns/1ps
interface omx_sel_if;
  logic [1:0] comb_code;
  logic       cdr_locked;
  logic       rate_above_3g;
  logic [2:0] pri_code;
  logic [2:0] sec_code;
  logic       sec_div_pick;

  modport auto_sel (
    input  comb_code,
    input  cdr_locked,
    input  rate_above_3g,
    output pri_code,
    output sec_code,
    output sec_div_pick
  );

  modport ctrl (
    output comb_code,
    output cdr_locked,
    output rate_above_3g,
    input  pri_code,
    input  sec_code,
    input  sec_div_pick
  );
endinterface : omx_sel_if

/* rtl/omx_auto_select.sv */
// Automatic source selection from the combined output control code
`timescale 1ns/1ps
module omx_auto_select (
  omx_sel_if.auto_sel sel
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode of combined code, lock state and rate class
  always_comb begin
    sel.pri_code     = omx_pkg::PRI_MUTE;
    sel.sec_code     = omx_pkg::SEC_MUTE;
    sel.sec_div_pick = omx_pkg::DIV_PICK_10M;
    unique case (sel.comb_code)
      omx_pkg::COMB_MUTE_BOTH: begin
        sel.pri_code = omx_pkg::PRI_MUTE;
        sel.sec_code = omx_pkg::SEC_MUTE;
      end
      omx_pkg::COMB_CLK_OUT: begin
        if (sel.cdr_locked) begin
          sel.pri_code = omx_pkg::PRI_RETIMED;
          if (sel.rate_above_3g) begin
            sel.sec_code     = omx_pkg::SEC_DIVCLK;
            sel.sec_div_pick = omx_pkg::DIV_PICK_DIV40;
          end else begin
            sel.sec_code = omx_pkg::SEC_OSC;
          end
        end else begin
          sel.pri_code = omx_pkg::PRI_RAW;
          sel.sec_code = omx_pkg::SEC_MUTE;
        end
      end
      omx_pkg::COMB_RETIMED: begin
        if (sel.cdr_locked) begin
          sel.pri_code = omx_pkg::PRI_RETIMED;
          sel.sec_code = omx_pkg::SEC_RETIMED;
        end else begin
          sel.pri_code = omx_pkg::PRI_RAW;
          sel.sec_code = omx_pkg::SEC_RAW;
        end
      end
      omx_pkg::COMB_RAW: begin
        sel.pri_code = omx_pkg::PRI_RAW;
        sel.sec_code = omx_pkg::SEC_RAW;
      end
    endcase
  end

endmodule : omx_auto_select

/* rtl/omx_top.sv */
// Output mux select register bank and applied source selection
`timescale 1ns/1ps
// Operation
// - Primary field reads applied code when not overridden
// - Override enable takes primary source from field
// - Primary codes: mute, 10 MHz, raw, retimed
// - Combined field replaces pin when pin-override set
// - Combined 00 mutes both outputs
// - Combined 01: retimed plus clock, else raw/mute
// - Combined 10: retimed when locked, raw otherwise
// - Combined 11: raw data on both outputs
// - Secondary field reads applied code normally
// - Override takes secondary source from its field
module omx_top (
  input  wire logic       CLK,
  input  wire logic       SRST,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  output logic            REG_RVALID,
  input  wire logic [1:0] OUT_CTRL_PIN,
  input  wire logic       CDR_LOCKED,
  input  wire logic       RATE_ABOVE_3G,
  input  wire logic       OVERRIDE_EN,
  input  wire logic       PIN_OVERRIDE_EN,
  output logic      [2:0] PRIMARY_SOURCE_CODE,
  output logic      [2:0] SECONDARY_SOURCE_CODE,
  output logic            SECONDARY_CLOCK_DIVIDE_PICK,
  output logic            PRIMARY_OUTPUT_MUTED,
  output logic            SECONDARY_OUTPUT_MUTED
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0]                      bank_q [omx_pkg::BANK_REGS];
  logic [omx_pkg::SYNC_BITS-1:0]   sync1_q;
  logic [omx_pkg::SYNC_BITS-1:0]   sync2_q;
  logic [omx_pkg::SYNC_BITS-1:0]   sync3_q;
  logic [omx_pkg::SYNC_BITS-1:0]   pins_q;
  logic [omx_pkg::SYNC_BITS-1:0]   pins_raw;
  logic [7:0]                      offset;
  logic [omx_pkg::IDX_W-1:0]       idx;
  logic                            in_bank;
  logic [1:0]                      comb_sel;
  logic [2:0]                      pri_d;
  logic [2:0]                      sec_d;
  logic                            pick_d;
  logic [7:0]                      rdata_d;
  logic [2:0]                      pri_q;
  logic [2:0]                      sec_q;
  logic                            pick_q;
  logic                            pri_mute_q;
  logic                            sec_mute_q;
  logic [7:0]                      rdata_q;
  logic                            rvalid_q;

  // Decoded fields and read views
  logic [omx_pkg::BANK_REGS-1:0]   wr_hit;
  logic [2:0]                      pri_field;
  logic [2:0]                      sec_field;
  logic                            pick_field;
  logic [1:0]                      comb_field;
  logic [2:0]                      pri_view;
  logic [2:0]                      sec_view;

  omx_sel_if sel ();

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  always_comb begin
    offset  = REG_ADDR - omx_pkg::BANK_FIRST_OFS;
    in_bank = (REG_ADDR >= omx_pkg::BANK_FIRST_OFS) &&
              (offset < 8'(omx_pkg::BANK_REGS));
    idx     = offset[omx_pkg::IDX_W-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write strobe per entry
  for (genvar h = 0; h < omx_pkg::BANK_REGS; h++) begin : g_wr_hit
    assign wr_hit[h] = REG_WR && in_bank &&
                       (idx == omx_pkg::IDX_W'(h));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage, one entry per offset
  for (genvar g = 0; g < omx_pkg::BANK_REGS; g++) begin : g_bank
    always_ff @(posedge CLK) begin
      if (SRST) begin
        bank_q[g] <= omx_pkg::BANK_RESET[g];
      end else if (wr_hit[g]) begin
        bank_q[g] <= REG_WDATA;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Three-stage synchronisers for pin and lock inputs
  assign pins_raw = {RATE_ABOVE_3G, CDR_LOCKED, OUT_CTRL_PIN};

  for (genvar b = 0; b < omx_pkg::SYNC_BITS; b++) begin : g_sync
    // Stage one is the only reader of the raw pin
    always_ff @(posedge CLK) begin
      if (SRST) begin
        sync1_q[b] <= omx_pkg::SYNC_RESET[b];
      end else begin
        sync1_q[b] <= pins_raw[b];
      end
    end

    always_ff @(posedge CLK) begin
      if (SRST) begin
        sync2_q[b] <= omx_pkg::SYNC_RESET[b];
      end else begin
        sync2_q[b] <= sync1_q[b];
      end
    end

    always_ff @(posedge CLK) begin
      if (SRST) begin
        sync3_q[b] <= omx_pkg::SYNC_RESET[b];
      end else begin
        sync3_q[b] <= sync2_q[b];
      end
    end

    // Accept a change once stages two and three agree
    always_ff @(posedge CLK) begin
      if (SRST) begin
        pins_q[b] <= omx_pkg::SYNC_RESET[b];
      end else if (sync2_q[b] == sync3_q[b]) begin
        pins_q[b] <= sync3_q[b];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fields of the primary select register
  always_comb begin
    pri_field  = bank_q[omx_pkg::PRI_IDX]
                 [omx_pkg::PRI_CODE_LSB +: omx_pkg::CODE_W];
    pick_field = bank_q[omx_pkg::PRI_IDX][omx_pkg::DIV_PICK_BIT];
    comb_field = bank_q[omx_pkg::PRI_IDX]
                 [omx_pkg::COMB_CTRL_LSB +: omx_pkg::COMB_W];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field of the secondary select register
  always_comb begin
    sec_field = bank_q[omx_pkg::SEC_IDX]
                [omx_pkg::SEC_CODE_LSB +: omx_pkg::CODE_W];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Combined control source: field or external pin
  always_comb begin
    if (PIN_OVERRIDE_EN) begin
      comb_sel = comb_field;
    end else begin
      comb_sel = pins_q[1:0];
    end
  end

  assign sel.comb_code     = comb_sel;
  assign sel.cdr_locked    = pins_q[2];
  assign sel.rate_above_3g = pins_q[3];

  omx_auto_select u_auto (
    .sel (sel.auto_sel)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Applied selection: override fields or automatic decode
  always_comb begin
    if (OVERRIDE_EN) begin
      pri_d = pri_field;
    end else begin
      pri_d = sel.pri_code;
    end
  end

  always_comb begin
    if (OVERRIDE_EN) begin
      sec_d = sec_field;
    end else begin
      sec_d = sel.sec_code;
    end
  end

  always_comb begin
    if (OVERRIDE_EN) begin
      pick_d = pick_field;
    end else begin
      pick_d = sel.sec_div_pick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Applied codes, registered toward the pins
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pri_q <= omx_pkg::PRI_RAW;
    end else begin
      pri_q <= pri_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      sec_q <= omx_pkg::SEC_RAW;
    end else begin
      sec_q <= sec_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      pick_q <= omx_pkg::DIV_PICK_10M;
    end else begin
      pick_q <= pick_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mute flags follow the applied codes
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pri_mute_q <= 1'h0;
    end else begin
      pri_mute_q <= (pri_d == omx_pkg::PRI_MUTE);
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      sec_mute_q <= 1'h0;
    end else begin
      sec_mute_q <= (sec_d == omx_pkg::SEC_MUTE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Code seen in each select field on a read
  always_comb begin
    if (OVERRIDE_EN) begin
      pri_view = pri_field;
    end else begin
      pri_view = pri_q;
    end
  end

  always_comb begin
    if (OVERRIDE_EN) begin
      sec_view = sec_field;
    end else begin
      sec_view = sec_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data; select fields return applied codes when not overridden
  always_comb begin
    rdata_d = 8'h00;
    if (in_bank) begin
      rdata_d = bank_q[idx];
      if (idx == omx_pkg::PRI_IDX) begin
        rdata_d[omx_pkg::PRI_CODE_LSB +: omx_pkg::CODE_W] = pri_view;
      end
      if (idx == omx_pkg::SEC_IDX) begin
        rdata_d[omx_pkg::SEC_CODE_LSB +: omx_pkg::CODE_W] = sec_view;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      rvalid_q <= 1'h0;
    end else begin
      rvalid_q <= REG_RD;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      rdata_q <= 8'h00;
    end else if (REG_RD) begin
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign REG_RDATA                   = rdata_q;
  assign REG_RVALID                  = rvalid_q;
  assign PRIMARY_SOURCE_CODE         = pri_q;
  assign SECONDARY_SOURCE_CODE       = sec_q;
  assign SECONDARY_CLOCK_DIVIDE_PICK = pick_q;
  assign PRIMARY_OUTPUT_MUTED        = pri_mute_q;
  assign SECONDARY_OUTPUT_MUTED      = sec_mute_q;

endmodule : omx_top

/* sim/omx_monitor.sv */
// Port checker for the output mux select bank
`timescale 1ns/1ps
module omx_monitor (
  input wire logic       CLK,
  input wire logic       SRST,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic       REG_WR,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic       REG_RVALID,
  input wire logic       OVERRIDE_EN,
  input wire logic       PIN_OVERRIDE_EN,
  input wire logic [2:0] PRIMARY_SOURCE_CODE,
  input wire logic [2:0] SECONDARY_SOURCE_CODE,
  input wire logic       SECONDARY_CLOCK_DIVIDE_PICK,
  input wire logic       PRIMARY_OUTPUT_MUTED,
  input wire logic       SECONDARY_OUTPUT_MUTED
);
  logic [7:0] pri_q;
  logic [7:0] sec_q;
  logic       ovr;
  logic       comb_on;
  logic [1:0] comb;
  logic [2:0] pcode;
  logic [2:0] scode;
  logic [4:0] plow;
  logic       pick;
  assign ovr     = OVERRIDE_EN && !SRST;
  assign comb_on = PIN_OVERRIDE_EN && !OVERRIDE_EN && !SRST;
  assign comb    = pri_q[3:2];
  assign pcode   = pri_q[7:5];
  assign scode   = sec_q[7:5];
  assign plow    = pri_q[4:0];
  assign pick    = pri_q[4];
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pri_q <= 8'h58;
      sec_q <= 8'h09;
    end else if (REG_WR && REG_ADDR == 8'h1C) begin
      pri_q <= REG_WDATA;
    end else if (REG_WR && REG_ADDR == 8'h1E) begin
      sec_q <= REG_WDATA;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  sequence s_read(logic [7:0] a);
    REG_RD && REG_ADDR == a;
  endsequence
  sequence s_answer;
    REG_RVALID;
  endsequence
  a_rvalid_pulse: assert property (REG_RD |=> s_answer)
    else $error("no read answer");
  a_read_pri: assert property (s_read(8'h1C) ##0 !OVERRIDE_EN |=>
    REG_RDATA == {$past(PRIMARY_SOURCE_CODE), $past(plow)})
    else $error("primary readback wrong");
  a_read_sec: assert property (s_read(8'h1E) ##0 OVERRIDE_EN |=>
    REG_RDATA == $past(sec_q)) else $error("secondary readback wrong");
  a_pri_override: assert property ($past(ovr) |->
    PRIMARY_SOURCE_CODE == $past(pcode)) else $error("primary override");
  a_sec_override: assert property ($past(ovr) |->
    SECONDARY_SOURCE_CODE == $past(scode)) else $error("sec override");
  a_pick_override: assert property ($past(ovr) |->
    SECONDARY_CLOCK_DIVIDE_PICK == $past(pick)) else $error("pick wrong");
  a_mute_flags: assert property (
    PRIMARY_OUTPUT_MUTED == (PRIMARY_SOURCE_CODE == 3'h0) &&
    SECONDARY_OUTPUT_MUTED == (SECONDARY_SOURCE_CODE == 3'h7))
    else $error("muted flags wrong");
  a_comb_mute: assert property ($past(comb_on) && $past(comb) == 2'h0
    |-> PRIMARY_SOURCE_CODE == 3'h0 && SECONDARY_SOURCE_CODE == 3'h7)
    else $error("combined mute");
  a_comb_raw: assert property ($past(comb_on) && $past(comb) == 2'h3
    |-> PRIMARY_SOURCE_CODE == 3'h2 && SECONDARY_SOURCE_CODE == 3'h0)
    else $error("combined raw");
  a_comb_retimed: assert property ($past(comb_on) &&
    $past(comb) == 2'h2 |->
    {PRIMARY_SOURCE_CODE, SECONDARY_SOURCE_CODE} inside {6'h21, 6'h10})
    else $error("combined retimed");
endmodule : omx_monitor

bind omx_top omx_monitor i_omx_monitor (.CLK(CLK), .SRST(SRST),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
  .OVERRIDE_EN(OVERRIDE_EN), .PIN_OVERRIDE_EN(PIN_OVERRIDE_EN),
  .PRIMARY_SOURCE_CODE(PRIMARY_SOURCE_CODE),
  .SECONDARY_SOURCE_CODE(SECONDARY_SOURCE_CODE),
  .SECONDARY_CLOCK_DIVIDE_PICK(SECONDARY_CLOCK_DIVIDE_PICK),
  .PRIMARY_OUTPUT_MUTED(PRIMARY_OUTPUT_MUTED),
  .SECONDARY_OUTPUT_MUTED(SECONDARY_OUTPUT_MUTED));

/* sim/testbench.sv */
// Self-checking bench for the output mux select bank
`timescale 1ns/1ps
module testbench;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr_s = 1'b0;
  logic       rd_s = 1'b0;
  logic [1:0] pin = 2'h2;
  logic       lock = 1'b0;
  logic       rate = 1'b0;
  logic       ovr = 1'b0;
  logic       povr = 1'b0;
  logic [7:0] rdata;
  logic       rvalid;
  logic [2:0] pri;
  logic [2:0] sec;
  logic       pick;
  logic       pmut;
  logic       smut;
  int         mismatches = 0;
  int         checks = 0;
  logic [7:0] rv;
  logic [6:0] ev;
  logic [2:0] pc [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
  logic [2:0] sc [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h7};
  always #10 clk = ~clk;
  omx_top i_omx_top (.CLK(clk), .SRST(srst), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .OUT_CTRL_PIN(pin), .CDR_LOCKED(lock),
    .RATE_ABOVE_3G(rate), .OVERRIDE_EN(ovr), .PIN_OVERRIDE_EN(povr),
    .PRIMARY_SOURCE_CODE(pri), .SECONDARY_SOURCE_CODE(sec),
    .SECONDARY_CLOCK_DIVIDE_PICK(pick), .PRIMARY_OUTPUT_MUTED(pmut),
    .SECONDARY_OUTPUT_MUTED(smut));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string w, input logic [7:0] s,
                       input logic [7:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", w, e, s);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    @(negedge clk);
    wr_s = 1'b0;
    repeat (2) @(negedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    addr = a;
    rd_s = 1'b1;
    @(negedge clk);
    rd_s = 1'b0;
    check("rvalid", {7'h0, rvalid}, 8'h01);
    rv = rdata;
  endtask : rd
  task automatic outs(input logic [6:0] e);
    check("outputs", {1'b0, pri, sec, pick}, {1'b0, e});
    check("muted", {6'h0, pmut, smut},
          {6'h0, e[6:4] == 3'h0, e[3:1] == 3'h7});
  endtask : outs
  function automatic logic [6:0] auto_exp(input logic [1:0] c,
                                          input logic l, input logic r);
    case (c)
      2'h0: auto_exp = 7'h0E;
      2'h1: auto_exp = !l ? 7'h2E : (r ? 7'h4B : 7'h44);
      2'h2: auto_exp = l ? 7'h42 : 7'h20;
      default: auto_exp = 7'h20;
    endcase
  endfunction : auto_exp
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    mismatches++;
    complete_run();
  end
  initial begin
    repeat (3) @(negedge clk);
    srst = 1'b0;
    ovr = 1'b1;
    for (int i = 0; i < 9; i++) begin
      rd(8'h16 + i[7:0]);
      check("reset", rv, omx_pkg::BANK_RESET[i]);
    end
    wr(8'h1F, 8'hFF);
    rd(8'h1F);
    check("unmapped", rv, 8'h00);
    foreach (pc[i]) begin
      wr(8'h1C, {pc[i], 5'h18});
      outs({pc[i], 3'h0, 1'b1});
      rd(8'h1C);
      check("pri field", rv, {pc[i], 5'h18});
    end
    for (int k = 0; k < 2; k++) begin
      wr(8'h1C, {3'h4, k[0], 4'h8});
      foreach (sc[j]) begin
        wr(8'h1E, {sc[j], 5'h09});
        outs({3'h4, sc[j], k[0]});
      end
    end
    ovr = 1'b0;
    povr = 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(8'h1C, {4'h0, c[1:0], 2'h0});
      for (int m = 0; m < 4; m++) begin
        lock = m[1];
        rate = m[0];
        repeat (6) @(negedge clk);
        ev = auto_exp(c[1:0], m[1], m[0]);
        outs(ev);
        rd(8'h1C);
        check("pri applied", rv, {ev[6:4], 1'h0, c[1:0], 2'h0});
        rd(8'h1E);
        check("sec applied", rv, {ev[3:1], 5'h09});
      end
    end
    povr = 1'b0;
    for (int c = 0; c < 4; c++) begin
      pin = c[1:0];
      repeat (6) @(negedge clk);
      outs(auto_exp(c[1:0], 1'b1, 1'b1));
    end
    srst = 1'b1;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    rd(8'h1C);
    check("pri after reset", rv, 8'h58);
    complete_run();
  end
endmodule : testbench
